// ===== rtl/low_voltage_stop_control.sv
// Overview of operation
// - With detection enabled, a detect event sets the read-only detect flag, bit 7.
// - Writing 1 to bit 6 clears the detect flag; bit 6 reads 0.
// - Detect flag and interrupt enable bit 5 together raise an interrupt request.
// - Write-once reset enable bit 4 with detection on forces reset on flag.
// - Stop enable bit 3 keeps detection running in stop; 0 disables it.
// - Write-once enable bit 2 turns detection on and gates bits 5 to 3; bit 0 is not gated.
// - Bit 0 enables the bandgap reference buffer for the converter.
// - Write-once bits take only the first write after reset.
// - Warning flag sets while supply is under warning trip, and stays set.
// - Warning acknowledge clears the flag only when no warning is present.
// - Bit 5 of second register selects high or low detect trip point.
// - Bit 4 of second register selects high or low warning trip point.
// - Partial power-down flag reads 1 after recovery from that stop mode.
// - Writing 1 to bit 2 clears the partial power-down flag.
// - Write-once bit 0 picks retained-logic stop (0) or partial power-down stop (1).
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module low_voltage_stop_control (
   input  wire logic                                clk,
   input  wire logic                                reset,
   input  wire logic                                sys_reset,
   input  wire logic [power_ctrl_pkg::ADDR_W-1:0]   addr,
   input  wire logic [power_ctrl_pkg::DATA_W-1:0]   wr_data,
   input  wire logic                                wr_en,
   input  wire logic                                rd_en,
   output logic      [power_ctrl_pkg::DATA_W-1:0]   rd_data,
   input  wire logic                                detect_event,
   input  wire logic                                warning_present,
   input  wire logic                                stop_active,
   input  wire logic                                ppd_recovery,
   output logic                                     detector_active,
   output logic                                     detect_irq,
   output logic                                     detect_reset_req,
   output logic                                     bandgap_buffer_en,
   output logic                                     detect_trip_high,
   output logic                                     warning_trip_high,
   output logic                                     partial_powerdown_sel,
   output logic                                     irq
);
   logic                              detect_flag_q;
   logic                              detect_irq_enable_q;
   logic                              detect_reset_enable_q;
   logic                              detect_stop_enable_q;
   logic                              detect_enable_q;
   logic                              bandgap_buffer_enable_q;
   logic                              warning_flag_q;
   logic                              detect_trip_select_q;
   logic                              warning_trip_select_q;
   logic                              partial_powerdown_flag_q;
   logic                              stop_mode_select_q;
   logic                              once1_done_q;
   logic                              once2_done_q;
   logic [power_ctrl_pkg::EV_W-1:0]   ev_status_q;
   logic [power_ctrl_pkg::EV_W-1:0]   ev_mask_q;
   logic [power_ctrl_pkg::DATA_W-1:0] rd_data_q;
   logic                              any_reset;
   logic                              sel_det;
   logic                              sel_warn;
   logic                              sel_stat;
   logic                              sel_mask;
   logic                              wr_det;
   logic                              wr_warn;
   logic                              wr_mask;
   logic                              rd_stat;
   logic                              once1_ok;
   logic                              once2_ok;
   logic                              detect_set;
   logic                              detect_ack;
   logic                              warning_ack;
   logic                              ppd_ack;
   logic                              warning_rise;
   logic [power_ctrl_pkg::EV_W-1:0]   ev_in;
   logic [power_ctrl_pkg::DATA_W-1:0] rd_det;
   logic [power_ctrl_pkg::DATA_W-1:0] rd_warn;
   logic [power_ctrl_pkg::DATA_W-1:0] rd_mux;

   assign any_reset = reset | sys_reset;
   assign sel_det   = addr == power_ctrl_pkg::OFS_DETECT_CTRL;
   assign sel_warn  = addr == power_ctrl_pkg::OFS_WARN_STOP;
   assign sel_stat  = addr == power_ctrl_pkg::OFS_IRQ_STATUS;
   assign sel_mask  = addr == power_ctrl_pkg::OFS_IRQ_MASK;
   assign wr_det    = wr_en & sel_det;
   assign wr_warn   = wr_en & sel_warn;
   assign wr_mask   = wr_en & sel_mask;
   assign rd_stat   = rd_en & sel_stat;

   // Write-once fields only load while their register has not yet been written
   assign once1_ok  = wr_det & ~once1_done_q;
   assign once2_ok  = wr_warn & ~once2_done_q;

   // Comparator is only trusted while it is powered
   assign detector_active = detect_enable_q & (~stop_active | detect_stop_enable_q);
   assign detect_set   = detector_active & detect_event;
   assign detect_ack   = wr_det & wr_data[power_ctrl_pkg::B_DETECT_ACK];
   assign warning_ack  = wr_warn & wr_data[power_ctrl_pkg::B_WARN_ACK];
   assign ppd_ack      = wr_warn & wr_data[power_ctrl_pkg::B_PPD_ACK];
   assign warning_rise = warning_present & ~warning_flag_q;

   assign detect_irq       = detect_flag_q & detect_irq_enable_q;
   assign detect_reset_req = detect_flag_q & detect_reset_enable_q & detect_enable_q;
   assign bandgap_buffer_en     = bandgap_buffer_enable_q;
   assign detect_trip_high      = detect_trip_select_q;
   assign warning_trip_high     = warning_trip_select_q;
   assign partial_powerdown_sel = stop_mode_select_q;

   assign ev_in = {ppd_recovery & ~partial_powerdown_flag_q,
                   warning_rise,
                   detect_set & ~detect_flag_q};
   assign irq = |(ev_status_q & ev_mask_q);

   // Acknowledge bits and reserved bits read as zero
   assign rd_det  = {detect_flag_q, 1'b0, detect_irq_enable_q, detect_reset_enable_q,
                     detect_stop_enable_q, detect_enable_q, 1'b0, bandgap_buffer_enable_q};
   assign rd_warn = {warning_flag_q, 1'b0, detect_trip_select_q, warning_trip_select_q,
                     partial_powerdown_flag_q, 2'b00, stop_mode_select_q};
   assign rd_mux  = sel_det  ? rd_det :
                    sel_warn ? rd_warn :
                    sel_stat ? {5'h00, ev_status_q} :
                    sel_mask ? {5'h00, ev_mask_q} : 8'h00;
   assign rd_data = rd_data_q;

   // Set wins over acknowledge in the same cycle so no event is lost
   always_ff @(posedge clk) begin
      if (any_reset) begin
         detect_flag_q <= power_ctrl_pkg::RST_BIT;
      end else if (detect_set) begin
         detect_flag_q <= 1'b1;
      end else if (detect_ack) begin
         detect_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         detect_irq_enable_q     <= power_ctrl_pkg::RST_BIT;
         detect_stop_enable_q    <= power_ctrl_pkg::RST_BIT;
         bandgap_buffer_enable_q <= power_ctrl_pkg::RST_BIT;
      end else if (wr_det) begin
         detect_irq_enable_q     <= wr_data[power_ctrl_pkg::B_DETECT_IRQEN];
         detect_stop_enable_q    <= wr_data[power_ctrl_pkg::B_DETECT_STOPEN];
         bandgap_buffer_enable_q <= wr_data[power_ctrl_pkg::B_BANDGAP_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         detect_reset_enable_q <= power_ctrl_pkg::RST_BIT;
         detect_enable_q       <= power_ctrl_pkg::RST_BIT;
         once1_done_q          <= power_ctrl_pkg::RST_BIT;
      end else if (once1_ok) begin
         detect_reset_enable_q <= wr_data[power_ctrl_pkg::B_DETECT_RSTEN];
         detect_enable_q       <= wr_data[power_ctrl_pkg::B_DETECT_EN];
         once1_done_q          <= 1'b1;
      end
   end

   // Warning flag is re-set every cycle the warning is present, so an ack during it fails
   always_ff @(posedge clk) begin
      if (any_reset) begin
         warning_flag_q <= power_ctrl_pkg::RST_BIT;
      end else if (warning_present) begin
         warning_flag_q <= 1'b1;
      end else if (warning_ack) begin
         warning_flag_q <= 1'b0;
      end
   end

   // Trip selects only clear on power-on reset
   always_ff @(posedge clk) begin
      if (reset) begin
         detect_trip_select_q  <= power_ctrl_pkg::RST_BIT;
         warning_trip_select_q <= power_ctrl_pkg::RST_BIT;
      end else if (wr_warn) begin
         detect_trip_select_q  <= wr_data[power_ctrl_pkg::B_DETECT_TRIP];
         warning_trip_select_q <= wr_data[power_ctrl_pkg::B_WARN_TRIP];
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         partial_powerdown_flag_q <= power_ctrl_pkg::RST_BIT;
      end else if (ppd_recovery) begin
         partial_powerdown_flag_q <= 1'b1;
      end else if (ppd_ack) begin
         partial_powerdown_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         stop_mode_select_q <= power_ctrl_pkg::RST_BIT;
         once2_done_q       <= power_ctrl_pkg::RST_BIT;
      end else if (once2_ok) begin
         stop_mode_select_q <= wr_data[power_ctrl_pkg::B_STOP_MODE];
         once2_done_q       <= 1'b1;
      end
   end

   // Read clears status; a new event in the same cycle survives
   always_ff @(posedge clk) begin
      if (any_reset) begin
         ev_status_q <= power_ctrl_pkg::RST_EVENTS;
      end else begin
         ev_status_q <= (rd_stat ? power_ctrl_pkg::RST_EVENTS : ev_status_q) | ev_in;
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         ev_mask_q <= power_ctrl_pkg::RST_EVENTS;
      end else if (wr_mask) begin
         ev_mask_q <= wr_data[power_ctrl_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         rd_data_q <= power_ctrl_pkg::RST_RDATA;
      end else begin
         rd_data_q <= rd_en ? rd_mux : power_ctrl_pkg::RST_RDATA;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_detect_flag_set: assert property (!sys_reset && detect_set |=> detect_flag_q)
      else $error("detect flag not set by event");
   chk_detect_ack_clear: assert property (!sys_reset && detect_ack && !detect_set |=> !detect_flag_q)
      else $error("detect flag not cleared by ack");
   chk_detect_irq_out: assert property (!sys_reset && detect_set && detect_irq_enable_q && !wr_det
                                        |=> detect_irq)
      else $error("detect interrupt missing");
   chk_reset_req_gate: assert property (detect_reset_req |-> detect_enable_q && detect_flag_q)
      else $error("reset request without enabled flag");
   chk_stop_gate_off: assert property (stop_active && !detect_stop_enable_q |-> !detector_active)
      else $error("detector running in stop");
   chk_write_once_hold: assert property (!sys_reset && wr_det && once1_done_q |=> $stable(detect_enable_q)
                                         && $stable(detect_reset_enable_q))
      else $error("write-once bit changed twice");
   chk_warning_hold: assert property (!sys_reset && warning_present |=> warning_flag_q[*1])
      else $error("warning flag lost while warning present");
   chk_ppd_ack_clear: assert property (!sys_reset && ppd_ack && !ppd_recovery |=> !partial_powerdown_flag_q)
      else $error("partial power-down flag not cleared");
   chk_trip_keep: assert property (sys_reset |=> $stable(detect_trip_select_q)
                                   && $stable(warning_trip_select_q))
      else $error("trip select lost on non power-on reset");
   chk_ack_reads_zero: assert property (rd_en && (sel_det || sel_warn) |=> !rd_data[6])
      else $error("acknowledge bit read as one");

   // Flag checks work from causes, so a broken flop shows up; chk_irq_holds and chk_reset_req_on_set check the output expressions
   chk_detect_idle_hold: assert property (
      !sys_reset && !detect_set && !detect_ack
      |=> $stable(detect_flag_q))
      else $error("detect flag changed with no cause");

   chk_flag_needs_enable: assert property (
      !detect_enable_q
      |-> !detect_flag_q)
      else $error("detect flag set while detection off");

   chk_stop_no_detect: assert property (
      !sys_reset && stop_active && !detect_stop_enable_q && !detect_flag_q
      |=> !detect_flag_q)
      else $error("detect flag set in stop with stop enable off");

   chk_irq_holds: assert property (
      !sys_reset && detect_flag_q && detect_irq_enable_q && !wr_det
      |=> detect_irq)
      else $error("detect interrupt dropped while flag set");

   chk_reset_req_on_set: assert property (
      !sys_reset && detect_set && detect_reset_enable_q
      |=> detect_reset_req)
      else $error("reset request missing after detect");

   chk_detect_event_status: assert property (
      !sys_reset && detect_set && !detect_flag_q
      |=> ev_status_q[power_ctrl_pkg::B_EV_DETECT])
      else $error("detect event not recorded in status");

   chk_ack_zero_keep: assert property (
      !sys_reset && wr_det && !wr_data[power_ctrl_pkg::B_DETECT_ACK] && detect_flag_q
      |=> detect_flag_q)
      else $error("detect flag cleared by zero ack");

   // Register write and reset checks
   chk_once_en_on: assert property (
      !sys_reset && wr_det && !once1_done_q && wr_data[power_ctrl_pkg::B_DETECT_EN]
      |=> detect_enable_q)
      else $error("first write did not set detect enable");

   chk_once_en_off: assert property (
      !sys_reset && wr_det && !once1_done_q && !wr_data[power_ctrl_pkg::B_DETECT_EN]
      |=> !detect_enable_q)
      else $error("first write did not clear detect enable");

   chk_rsten_first: assert property (
      !sys_reset && wr_det && !once1_done_q && wr_data[power_ctrl_pkg::B_DETECT_RSTEN]
      |=> detect_reset_enable_q)
      else $error("first write did not set reset enable");

   chk_once_stop_mode: assert property (
      !sys_reset && wr_warn && once2_done_q
      |=> $stable(stop_mode_select_q))
      else $error("stop mode select changed twice");

   chk_stop_mode_first: assert property (
      !sys_reset && wr_warn && !once2_done_q && wr_data[power_ctrl_pkg::B_STOP_MODE]
      |=> partial_powerdown_sel)
      else $error("partial power-down stop not selected");

   chk_bandgap_write: assert property (
      !sys_reset && wr_det && wr_data[power_ctrl_pkg::B_BANDGAP_EN]
      |=> bandgap_buffer_en)
      else $error("bandgap buffer not enabled by write");

   chk_stopen_write: assert property (
      !sys_reset && wr_det && !wr_data[power_ctrl_pkg::B_DETECT_STOPEN]
      |=> !detect_stop_enable_q)
      else $error("stop enable not cleared by write");

   chk_irqen_write: assert property (
      !sys_reset && wr_det && !wr_data[power_ctrl_pkg::B_DETECT_IRQEN]
      |=> !detect_irq)
      else $error("detect interrupt with enable written off");

   chk_detect_trip_write: assert property (
      wr_warn && wr_data[power_ctrl_pkg::B_DETECT_TRIP]
      |=> detect_trip_high)
      else $error("high detect trip not selected");

   chk_warn_trip_write: assert property (
      wr_warn && !wr_data[power_ctrl_pkg::B_WARN_TRIP]
      |=> !warning_trip_high)
      else $error("low warning trip not selected");

   chk_sys_reset_clears: assert property (
      sys_reset
      |=> !detect_flag_q && !partial_powerdown_flag_q && !detect_enable_q && !stop_mode_select_q)
      else $error("state kept across non power-on reset");

   // Warning and partial power-down flags
   chk_warning_ack_clear: assert property (
      !sys_reset && warning_ack && !warning_present
      |=> !warning_flag_q)
      else $error("warning flag not cleared by ack");

   chk_warning_sticky: assert property (
      !sys_reset && warning_flag_q && !warning_ack
      |=> warning_flag_q)
      else $error("warning flag dropped without ack");

   chk_ppd_set: assert property (
      !sys_reset && ppd_recovery
      |=> partial_powerdown_flag_q)
      else $error("partial power-down flag not set on recovery");

   chk_ppd_sticky: assert property (
      !sys_reset && partial_powerdown_flag_q && !ppd_ack
      |=> partial_powerdown_flag_q)
      else $error("partial power-down flag dropped without ack");

   cov_detect_reset: cover property (detect_set ##1 detect_reset_req);
   cov_warning_ack: cover property (warning_flag_q && !warning_present && warning_ack ##1 !warning_flag_q);
   cov_ppd_cycle: cover property (ppd_recovery ##[1:20] ppd_ack);
   cov_irq_read: cover property (irq ##1 rd_stat);
   cov_trip_survive: cover property (sys_reset && warning_trip_high ##1 !sys_reset && warning_trip_high);
endmodule // low_voltage_stop_control

// ===== inc/power_ctrl_pkg.sv
package power_ctrl_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [7:0] OFS_DETECT_CTRL = 8'h00;
   localparam logic [7:0] OFS_WARN_STOP   = 8'h01;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h02;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h03;

   // low_voltage_detect_ctrl_status fields
   localparam int unsigned B_DETECT_FLAG  = 7;
   localparam int unsigned B_DETECT_ACK   = 6;
   localparam int unsigned B_DETECT_IRQEN = 5;
   localparam int unsigned B_DETECT_RSTEN = 4;
   localparam int unsigned B_DETECT_STOPEN = 3;
   localparam int unsigned B_DETECT_EN    = 2;
   localparam int unsigned B_BANDGAP_EN   = 0;

   // warning_and_stop_ctrl_status fields
   localparam int unsigned B_WARN_FLAG    = 7;
   localparam int unsigned B_WARN_ACK     = 6;
   localparam int unsigned B_DETECT_TRIP  = 5;
   localparam int unsigned B_WARN_TRIP    = 4;
   localparam int unsigned B_PPD_FLAG     = 3;
   localparam int unsigned B_PPD_ACK      = 2;
   localparam int unsigned B_STOP_MODE    = 0;

   // Interrupt status and mask fields
   localparam int unsigned B_EV_DETECT    = 0;
   localparam int unsigned B_EV_WARN      = 1;
   localparam int unsigned B_EV_PPD       = 2;
   localparam int unsigned EV_W           = 3;

   // Reset values
   localparam logic       RST_BIT         = 1'b0;
   localparam logic [2:0] RST_EVENTS      = 3'h0;
   localparam logic [7:0] RST_RDATA       = 8'h00;
endpackage

// ===== tb/low_voltage_stop_control_bench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module low_voltage_stop_control_bench;
   logic        clk;
   logic        reset;
   logic        sys_reset;
   logic [7:0]  addr;
   logic [7:0]  wr_data;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rd_data;
   logic        detect_event;
   logic        warning_present;
   logic        stop_active;
   logic        ppd_recovery;
   logic        detector_active;
   logic        detect_irq;
   logic        detect_reset_req;
   logic        bandgap_buffer_en;
   logic        detect_trip_high;
   logic        warning_trip_high;
   logic        partial_powerdown_sel;
   logic        irq;
   logic [7:0]  rv;
   logic [31:0] seed;
   int          mismatches;
   int          n_checks;

   low_voltage_stop_control u_low_voltage_stop_control (.clk(clk), .reset(reset), .sys_reset(sys_reset),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .detect_event(detect_event), .warning_present(warning_present), .stop_active(stop_active),
      .ppd_recovery(ppd_recovery), .detector_active(detector_active), .detect_irq(detect_irq),
      .detect_reset_req(detect_reset_req), .bandgap_buffer_en(bandgap_buffer_en),
      .detect_trip_high(detect_trip_high), .warning_trip_high(warning_trip_high),
      .partial_powerdown_sel(partial_powerdown_sel), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // Write-once bits 4 and 2 keep the first value, bits 5, 3 and 0 follow the latest write
   function automatic logic [7:0] ctrl_after(input logic [7:0] first, input logic [7:0] next);
      return (first & 8'h14) | (next & 8'h29);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      rv = rd_data;
   endtask

   task automatic pulse_por();
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1;
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Whole run is well under this span
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      {reset, sys_reset, wr_en, rd_en, detect_event, warning_present, stop_active, ppd_recovery} = 8'h80;
      addr = 8'h00;
      wr_data = 8'h00;
      seed = 32'hed9cc4d2;
      mismatches = 0;
      n_checks = 0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 4; a++) begin
         rd(a[7:0]);
         `CHK(rv, 8'h00)
      end
      rd(8'h10);
      `CHK(rv, 8'h00)
      $display("done: reset values");
      // Reserved bit 1 is always written as 0
      repeat (3) begin
         seed = xs(seed);
         wr(8'h00, seed[7:0] & 8'hfd);
         rd(8'h00);
         `CHK(rv, ctrl_after(seed[7:0], seed[7:0]))
         `CHK(bandgap_buffer_en, seed[0])
         pulse_por();
      end
      $display("done: random control writes");
      @(posedge clk) stop_active <= 1'b1;
      wr(8'h00, 8'h35);
      `CHK(detector_active, 1'b0)
      // Event while the detector is stopped must not reach the flag
      @(posedge clk) detect_event <= 1'b1;
      @(posedge clk) detect_event <= 1'b0;
      wr(8'h00, 8'h28);
      rd(8'h00);
      `CHK(rv, ctrl_after(8'h35, 8'h28))
      `CHK(detector_active, 1'b1)
      @(posedge clk) stop_active <= 1'b0;
      #1 `CHK(detector_active, 1'b1)
      $display("done: write once and stop enable");
      @(posedge clk) detect_event <= 1'b1;
      @(posedge clk) detect_event <= 1'b0;
      rd(8'h00);
      `CHK(rv, 8'hbc)
      `CHK(detect_irq, 1'b1)
      `CHK(detect_reset_req, 1'b1)
      wr(8'h00, 8'h28);
      rd(8'h00);
      `CHK(rv, 8'hbc)
      wr(8'h03, 8'h01);
      `CHK(irq, 1'b1)
      rd(8'h02);
      `CHK(rv, 8'h01)
      `CHK(irq, 1'b0)
      wr(8'h00, 8'h68);
      rd(8'h00);
      `CHK(rv, 8'h3c)
      `CHK(detect_irq, 1'b0)
      $display("done: detect flag and interrupt");
      wr(8'h01, 8'h71);
      `CHK({detect_trip_high, warning_trip_high, partial_powerdown_sel}, 3'h7)
      wr(8'h01, 8'h40);
      rd(8'h01);
      `CHK(rv, 8'h01)
      @(posedge clk) warning_present <= 1'b1;
      wr(8'h01, 8'h41);
      rd(8'h01);
      `CHK(rv, 8'h81)
      @(posedge clk) warning_present <= 1'b0;
      rd(8'h01);
      `CHK(rv, 8'h81)
      wr(8'h01, 8'h41);
      rd(8'h01);
      `CHK(rv, 8'h01)
      $display("done: warning flag");
      @(posedge clk) ppd_recovery <= 1'b1;
      @(posedge clk) ppd_recovery <= 1'b0;
      rd(8'h01);
      `CHK(rv, 8'h09)
      wr(8'h01, 8'h01);
      rd(8'h01);
      `CHK(rv, 8'h09)
      wr(8'h01, 8'h05);
      rd(8'h01);
      `CHK(rv, 8'h01)
      rd(8'h02);
      `CHK(rv, 8'h06)
      $display("done: partial power down");
      wr(8'h01, 8'h31);
      @(posedge clk) sys_reset <= 1'b1;
      repeat (2) @(posedge clk);
      sys_reset <= 1'b0;
      #1 `CHK({detect_trip_high, warning_trip_high}, 2'h3)
      rd(8'h01);
      `CHK(rv, 8'h30)
      pulse_por();
      rd(8'h01);
      `CHK(rv, 8'h00)
      $display("done: reset kinds");
      report_and_stop();
   end
endmodule // low_voltage_stop_control_bench
